// [dpd_top.sv]
// two plain-mode port groups on 48 lines plus two analog channel latches
// assumes an apb master; pins are sampled synchronously to pclk
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module dpd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [47:0] dio_in,
  output logic [47:0] dio_out,
  output logic [47:0] dio_oe,
  output logic [11:0] dac0_code,
  output logic [11:0] dac1_code,
  output logic [2:0] dac0_range,
  output logic [2:0] dac1_range,
  output logic dac0_range_chg,
  output logic dac1_range_chg
);
  typedef struct packed {
    logic [23:0] grp1;
    logic [23:0] grp2;
    logic [7:0] dir;
    logic simul;
    logic [31:0] rdata;
    logic err;
  } dpd_top_st_t;

  dpd_top_st_t s_r, s_nxt;
  logic setup, wr_acc, mapped, upd_all, rng_wr;
  logic [23:0] en1, en2;
  logic [31:0] rd_mux;

  // ============================================================
  // bank helpers
  // banks per group: a = bits 7:0, b = 15:8, c low = 19:16, c high = 23:20
  function automatic logic [23:0] bank_en(input logic [3:0] d);
    bank_en = {{4{d[3]}}, {4{d[2]}}, {8{d[1]}}, {8{d[0]}}};
  endfunction : bank_en

  // outputs read back their latch, inputs read the live pins
  function automatic logic [23:0] bank_rd(input logic [23:0] q,
                                          input logic [23:0] pins,
                                          input logic [23:0] en);
    bank_rd = (q & en) | (pins & ~en);
  endfunction : bank_rd

  assign en1 = bank_en(s_r.dir[3:0]);
  assign en2 = bank_en(s_r.dir[7:4]);

  // ============================================================
  // apb decode
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && !s_r.err;
  assign pready = psel && penable;
  assign pslverr = psel && penable && s_r.err;
  assign prdata = s_r.rdata;
  assign upd_all = wr_acc && (paddr == dpd_pkg::OFS_DCTL) &&
                   pwdata[dpd_pkg::UPD_BIT];
  assign rng_wr = wr_acc && (paddr == dpd_pkg::OFS_DCTL);

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      dpd_pkg::OFS_GRP1: rd_mux = {8'h00, bank_rd(s_r.grp1, dio_in[23:0],
                                                   en1)};
      dpd_pkg::OFS_GRP2: rd_mux = {8'h00, bank_rd(s_r.grp2, dio_in[47:24],
                                                   en2)};
      dpd_pkg::OFS_DIR: rd_mux = {24'h000000, s_r.dir};
      dpd_pkg::OFS_DAC0: rd_mux = {20'h00000, dac0_code};
      dpd_pkg::OFS_DAC1: rd_mux = {20'h00000, dac1_code};
      dpd_pkg::OFS_DCTL: rd_mux = {25'h0000000, s_r.simul, dac1_range,
                                   dac0_range};
      default: mapped = 1'b0;
    endcase
  end

  // ============================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    if (setup) begin
      // read data and the error flag are caught in the setup cycle
      s_nxt.rdata = pwrite ? 32'h00000000 : rd_mux;
      s_nxt.err = !mapped;
    end
    if (wr_acc) begin
      case (paddr)
        dpd_pkg::OFS_GRP1: s_nxt.grp1 = pwdata[23:0];
        dpd_pkg::OFS_GRP2: s_nxt.grp2 = pwdata[23:0];
        dpd_pkg::OFS_DIR: s_nxt.dir = pwdata[7:0];
        dpd_pkg::OFS_DCTL: s_nxt.simul = pwdata[dpd_pkg::SIMUL_BIT];
        default: s_nxt.dir = s_r.dir;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.grp1 <= dpd_pkg::RST_GRP;
      s_r.grp2 <= dpd_pkg::RST_GRP;
      s_r.dir <= dpd_pkg::RST_DIR;
      s_r.simul <= 1'b0;
      s_r.rdata <= 32'h00000000;
      s_r.err <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ============================================================
  // pins
  // no strobe or two-way port mode exists: a bank is only in or out
  assign dio_out = {s_r.grp2, s_r.grp1};
  assign dio_oe = {en2, en1};

  // ============================================================
  // analog channels
  dpd_dac_chan u_dac0 (
    .pclk(pclk),
    .presetn(presetn),
    .simul(s_r.simul),
    .data_wr(wr_acc && (paddr == dpd_pkg::OFS_DAC0)),
    .data(pwdata[11:0]),
    .upd_all(upd_all),
    .rng_wr(rng_wr),
    .rng(pwdata[dpd_pkg::RNG0_LSB +: dpd_pkg::RNG_W]),
    .code(dac0_code),
    .range(dac0_range),
    .range_chg(dac0_range_chg)
  );

  dpd_dac_chan u_dac1 (
    .pclk(pclk),
    .presetn(presetn),
    .simul(s_r.simul),
    .data_wr(wr_acc && (paddr == dpd_pkg::OFS_DAC1)),
    .data(pwdata[11:0]),
    .upd_all(upd_all),
    .rng_wr(rng_wr),
    .rng(pwdata[dpd_pkg::RNG1_LSB +: dpd_pkg::RNG_W]),
    .code(dac1_code),
    .range(dac1_range),
    .range_chg(dac1_range_chg)
  );

  // ============================================================
  // checks
  a_reset_all_input: assert property (@(posedge pclk)
    $rose(presetn) |-> dio_oe == 48'h000000000000)
    else $error("lines driven after reset");
  a_bank_whole: assert property (@(posedge pclk) disable iff (!presetn)
    dio_oe[7:0] == {8{s_r.dir[0]}} && dio_oe[23:20] == {4{s_r.dir[3]}} &&
    dio_oe[47:44] == {4{s_r.dir[7]}})
    else $error("bank enable not uniform");
  a_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == dpd_pkg::OFS_DIR |=>
    dio_oe[31:24] == {8{$past(pwdata[4])}})
    else $error("direction write not applied");
  a_out_hold: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == dpd_pkg::OFS_GRP1 |=>
    dio_out[23:0] == $past(pwdata[23:0]) ##1 $stable(dio_out) || wr_acc)
    else $error("output latch not driven");
  a_read_pins: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == dpd_pkg::OFS_GRP1 && !s_r.dir[0] |=>
    prdata[7:0] == $past(dio_in[7:0]))
    else $error("input bank did not read pins");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    setup && paddr == 8'h18 |=> pslverr || !penable)
    else $error("unmapped access not flagged");
  a_bank_split: assert property (@(posedge pclk)
    disable iff (!presetn)
    dio_oe[15:8] == {8{s_r.dir[1]}} && dio_oe[19:16] == {4{s_r.dir[2]}} &&
    dio_oe[43:40] == {4{s_r.dir[6]}})
    else $error("bank split wrong");
  a_dir_stable: assert property (@(posedge pclk)
    disable iff (!presetn)
    !(wr_acc && paddr == dpd_pkg::OFS_DIR) |=> $stable(dio_oe))
    else $error("direction changed without a write");
  a_err_no_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    psel && penable && pwrite && pslverr |=> $stable(s_r.dir))
    else $error("refused write changed direction");
  a_out_stable: assert property (@(posedge pclk)
    disable iff (!presetn)
    !(wr_acc && (paddr == dpd_pkg::OFS_GRP1 || paddr == dpd_pkg::OFS_GRP2))
    |=> $stable(dio_out))
    else $error("output latch changed without a write");
  a_grp2_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_acc && paddr == dpd_pkg::OFS_GRP2 |=>
    dio_out[47:24] == $past(pwdata[23:0]))
    else $error("group two write not applied");
  a_read_latch: assert property (@(posedge pclk)
    disable iff (!presetn)
    setup && !pwrite && paddr == dpd_pkg::OFS_GRP2 && s_r.dir[5] |=>
    prdata[15:8] == $past(dio_out[39:32]))
    else $error("output bank did not read its latch");
  a_range_set: assert property (@(posedge pclk)
    disable iff (!presetn)
    rng_wr && pwdata[dpd_pkg::RNG0_LSB +: dpd_pkg::RNG_W] <
    dpd_pkg::NUM_RANGES |=>
    dac0_range == $past(pwdata[dpd_pkg::RNG0_LSB +: dpd_pkg::RNG_W]))
    else $error("valid range not taken");
endmodule : dpd_top
`default_nettype wire

// [dpd_pkg.sv]
// constants for the dual port-group digital i/o and analog range block
// assumes an apb slave at byte addresses, one 32-bit word per register
// ============================================================
// Function
// - two independent 24-line groups, each with ports a, b and c.
// - only plain unstrobed i/o exists, no handshake or two-way port mode.
// - the 48 lines form four 8-line banks and four 4-line banks.
// - software sets each bank's direction and it applies to every line.
// - after power-up or any reset every bank is input and undriven.
// - there are two analog output channels, 0 and 1, each with its pin.
// - each channel holds one of six ranges, changeable at any time.
// - analog data is double buffered, updated singly or together.
// - reset clears every analog output latch to the zero-volt code.
package dpd_pkg;
  // ============================================================
  // register map
  localparam logic [7:0] OFS_GRP1 = 8'h00;
  localparam logic [7:0] OFS_GRP2 = 8'h04;
  localparam logic [7:0] OFS_DIR = 8'h08;
  localparam logic [7:0] OFS_DAC0 = 8'h0C;
  localparam logic [7:0] OFS_DAC1 = 8'h10;
  localparam logic [7:0] OFS_DCTL = 8'h14;
  // ============================================================
  // fields
  localparam int GRP_W = 24;
  localparam int DIR_W = 8;
  localparam int DIR_G2 = 4;
  localparam int DAC_W = 12;
  localparam int RNG_W = 3;
  localparam int RNG0_LSB = 0;
  localparam int RNG1_LSB = 3;
  localparam int SIMUL_BIT = 6;
  localparam int UPD_BIT = 7;
  // ============================================================
  // ranges: 0 +-10, 1 +-5, 2 +-2.5, 3 0-10, 4 0-5, 5 0-2.5 volts
  localparam logic [2:0] NUM_RANGES = 3'h6;
  localparam logic [2:0] FIRST_UNI = 3'h3;
  localparam logic [11:0] ZERO_BIP = 12'h800;
  localparam logic [11:0] ZERO_UNI = 12'h000;
  // ============================================================
  // reset values
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [23:0] RST_GRP = 24'h000000;
  localparam logic [2:0] RST_RNG = 3'h0;
  localparam logic [11:0] RST_CODE = ZERO_BIP;
endpackage : dpd_pkg

// [dpd_dac_chan.sv]
// one analog channel: input latch, output latch and range selection
// assumes the caller decodes writes and the update strobe
`timescale 1ns/1ns
`default_nettype none
module dpd_dac_chan (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic simul,
  input wire logic data_wr,
  input wire logic [11:0] data,
  input wire logic upd_all,
  input wire logic rng_wr,
  input wire logic [2:0] rng,
  output logic [11:0] code,
  output logic [2:0] range,
  output logic range_chg
);
  typedef struct packed {
    logic [11:0] hold;
    logic [11:0] out;
    logic [2:0] rng;
    logic chg;
  } dpd_chan_st_t;

  dpd_chan_st_t s_r, s_nxt;

  // ============================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.chg = 1'b0;
    if (data_wr) begin
      s_nxt.hold = data;
      if (!simul) begin
        s_nxt.out = data;
      end
    end
    if (upd_all) begin
      // a write in the same cycle as the strobe is included in the update
      s_nxt.out = data_wr ? data : s_r.hold;
    end
    // codes 6 and 7 name no range and leave the selection alone
    if (rng_wr && (rng < dpd_pkg::NUM_RANGES) && (rng != s_r.rng)) begin
      s_nxt.rng = rng;
      s_nxt.chg = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.hold <= dpd_pkg::RST_CODE;
      s_r.out <= dpd_pkg::RST_CODE;
      s_r.rng <= dpd_pkg::RST_RNG;
      s_r.chg <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign code = s_r.out;
  assign range = s_r.rng;
  assign range_chg = s_r.chg;

  // ============================================================
  // checks
  a_reset_zero_code: assert property (@(posedge pclk)
    $rose(presetn) |-> code == dpd_pkg::ZERO_BIP)
    else $error("output latch not at zero code after reset");
  a_single_update: assert property (@(posedge pclk) disable iff (!presetn)
    data_wr && !simul && !upd_all |=> code == $past(data))
    else $error("individual update did not load the output latch");
  a_simul_hold: assert property (@(posedge pclk) disable iff (!presetn)
    simul && !upd_all |=> $stable(code))
    else $error("output changed without update strobe");
  a_range_bad: assert property (@(posedge pclk) disable iff (!presetn)
    rng_wr && rng >= dpd_pkg::NUM_RANGES |=> $stable(range) && !range_chg)
    else $error("invalid range accepted");
  a_range_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    range_chg |-> range != $past(range) ##1 !range_chg)
    else $error("range change pulse wrong");
endmodule : dpd_dac_chan
`default_nettype wire

// [dpd_field_model.sv]
// field wiring model: outside devices on the 48 digital lines
// assumes pclk from the bench; unconnected lines float and wander
`timescale 1ns/1ns
`default_nettype none
module dpd_field_model (
  input wire logic pclk,
  input wire logic [47:0] dio_out,
  input wire logic [47:0] dio_oe,
  input wire logic [47:0] field,
  input wire logic [47:0] conn,
  output logic [47:0] dio_in
);
  // ============================================================
  // floating lines toggle so a stale level never passes
  logic [47:0] flt = 48'h000000000000;
  always @(posedge pclk) begin
    flt <= ~flt;
  end
  assign dio_in = (dio_oe & dio_out) |
    (~dio_oe & ((conn & field) | (~conn & flt)));
endmodule : dpd_field_model
`default_nettype wire

// [dpd_top_test.sv]
// self-checking bench for the port-group i/o and analog range block
// assumes dpd_top and dpd_field_model; the bench is the apb master
`timescale 1ns/1ns
`default_nettype none
module dpd_top_test;
  // ============================================================
  // signals and model state
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, g0, g1;
  logic [47:0] dio_in, dio_out, dio_oe, conn;
  logic [47:0] field = 48'h000000000000;
  logic [11:0] c0, c1;
  logic [2:0] r0, r1;
  logic [7:0] m_dir;
  logic [23:0] m_grp [2];
  logic [11:0] m_code [2];
  logic [11:0] m_hold [2];
  logic [2:0] m_rng [2];
  logic [2:0] v [2];
  logic p [2];
  logic m_sim;
  int fails = 0;
  int cmp_count = 0;
  int seed = 32'h5db7;
  int n0, n1;
  always #2 pclk = ~pclk;
  dpd_top u_dpd_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dio_in(dio_in),
    .dio_out(dio_out), .dio_oe(dio_oe), .dac0_code(c0), .dac1_code(c1),
    .dac0_range(r0), .dac1_range(r1), .dac0_range_chg(g0),
    .dac1_range_chg(g1));
  dpd_field_model u_dpd_field_model (.pclk(pclk), .dio_out(dio_out),
    .dio_oe(dio_oe), .field(field), .conn(conn), .dio_in(dio_in));
  // ============================================================
  // tasks
  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [47:0] seen,
      input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // request held until pready is seen high; a run with no pready in 50 cycles fails
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      conclude();
    end
  endtask : apb
  function automatic logic [47:0] mask(input logic [7:0] d);
    logic [47:0] m;
    for (int g = 0; g < 2; g++) begin
      m[g*24+:24] = {{4{d[g*4+3]}}, {4{d[g*4+2]}}, {8{d[g*4+1]}},
        {8{d[g*4]}}};
    end
    return m;
  endfunction : mask
  task automatic init_model;
    m_dir = 8'h00;
    m_sim = 1'b0;
    for (int c = 0; c < 2; c++) begin
      m_grp[c] = 24'h000000;
      m_code[c] = dpd_pkg::ZERO_BIP;
      m_hold[c] = dpd_pkg::ZERO_BIP;
      m_rng[c] = 3'h0;
    end
  endtask : init_model
  task automatic check_all;
    logic [47:0] m;
    logic [23:0] k, mg;
    logic [31:0] e [4];
    m = mask(m_dir);
    e = '{{24'h0, m_dir}, {20'h0, m_code[0]}, {20'h0, m_code[1]},
      {25'h0, m_sim, m_rng[1], m_rng[0]}};
    #1;
    chk("oe", dio_oe, m);
    chk("out", dio_out & m, {m_grp[1], m_grp[0]} & m);
    chk("codes", {24'h0, c1, c0}, {24'h0, m_code[1], m_code[0]});
    chk("ranges", {42'h0, r1, r0}, {42'h0, m_rng[1], m_rng[0]});
    for (int g = 0; g < 2; g++) begin
      mg = m[g*24+:24];
      k = mg | conn[g*24+:24];
      apb(1'b0, g ? dpd_pkg::OFS_GRP2 : dpd_pkg::OFS_GRP1, 32'h0);
      chk("grp", {24'h0, rd[23:0] & k}, {24'h0, ((m_grp[g] & mg) |
        (field[g*24+:24] & ~mg)) & k});
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, dpd_pkg::OFS_DIR + 8'(4 * i), 32'h0);
      chk("reg", {15'h0, err, rd}, {16'h0, e[i]});
    end
  endtask : check_all
  // ============================================================
  // main sequence
  initial begin
    conn = 48'({$random(seed), $random(seed)});
    init_model();
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    check_all();
    for (int i = 0; i < 6; i++) begin
      m_dir = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
      apb(1'b1, dpd_pkg::OFS_DIR, {24'h0, m_dir});
      for (int g = 0; g < 2; g++) begin
        m_grp[g] = 24'($random(seed));
        apb(1'b1, g ? dpd_pkg::OFS_GRP2 : dpd_pkg::OFS_GRP1,
          {8'h0, m_grp[g]});
      end
      field <= 48'({$random(seed), $random(seed)});
      check_all();
    end
    // unmapped places refuse and change nothing
    apb(1'b1, 8'h18, 32'hFFFFFFFF);
    chk("err", {15'h0, err, 32'h0}, {16'h1, 32'h0});
    apb(1'b0, 8'hFC, 32'h0);
    chk("err rd", {15'h0, err, rd}, {16'h1, 32'h0});
    for (int c = 0; c < 2; c++) begin
      m_code[c] = 12'($random(seed));
      m_hold[c] = m_code[c];
      apb(1'b1, c ? dpd_pkg::OFS_DAC1 : dpd_pkg::OFS_DAC0,
        {20'h0, m_code[c]});
      check_all();
    end
    // every range code on both channels, 6 and 7 refused
    for (int r = 0; r < 8; r++) begin
      v[0] = 3'(r);
      v[1] = 3'(7 - r);
      for (int c = 0; c < 2; c++) begin
        p[c] = (v[c] < dpd_pkg::NUM_RANGES) && (v[c] != m_rng[c]);
        if (p[c]) begin
          m_rng[c] = v[c];
        end
      end
      apb(1'b1, dpd_pkg::OFS_DCTL, {26'h0, v[1], v[0]});
      n0 = 0;
      n1 = 0;
      repeat (3) begin
        #1;
        if (g0 === 1'b1) n0++;
        if (g1 === 1'b1) n1++;
        @(posedge pclk);
      end
      chk("pulses", {n1[23:0], n0[23:0]}, {23'h0, p[1], 23'h0, p[0]});
      chk("rng", {42'h0, r1, r0}, {42'h0, m_rng[1], m_rng[0]});
    end
    // simultaneous mode: data waits for the update strobe
    m_sim = 1'b1;
    apb(1'b1, dpd_pkg::OFS_DCTL, {25'h0, 1'b1, m_rng[1], m_rng[0]});
    for (int c = 0; c < 2; c++) begin
      m_hold[c] = 12'($random(seed));
      apb(1'b1, c ? dpd_pkg::OFS_DAC1 : dpd_pkg::OFS_DAC0,
        {20'h0, m_hold[c]});
    end
    check_all();
    apb(1'b1, dpd_pkg::OFS_DCTL, {24'h0, 2'h3, m_rng[1], m_rng[0]});
    m_code[0] = m_hold[0];
    m_code[1] = m_hold[1];
    check_all();
    // reset in mid-run with all banks driven
    apb(1'b1, dpd_pkg::OFS_DIR, 32'h000000FF);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    init_model();
    check_all();
    conclude();
  end
endmodule : dpd_top_test
`default_nettype wire
